// [hw/pin_state_pkg.sv]
package pin_state_pkg;

   // Operating states, one-hot
   typedef enum logic [5:0] {
      ST_POR      = 6'h01,
      ST_EXT_RST  = 6'h02,
      ST_INT_RST  = 6'h04,
      ST_RUN      = 6'h08,
      ST_STANDBY  = 6'h10,
      ST_ILLEGAL  = 6'h20
   } op_state_t;

   // Function group codes per pin
   localparam logic [2:0] FG_GPIO      = 3'h0;
   localparam logic [2:0] FG_PERIPH    = 3'h1;
   localparam logic [2:0] FG_CLK_IN    = 3'h2;
   localparam logic [2:0] FG_OSC_IN    = 3'h3;
   localparam logic [2:0] FG_OSC_OUT   = 3'h4;
   localparam logic [2:0] FG_ANALOG    = 3'h5;
   localparam logic [2:0] FG_EXT_INT   = 3'h6;
   localparam logic [2:0] FG_ALWAYS_IN = 3'h7;

   localparam int FG_W = 3;
   localparam int PIN_COUNT = 8;

   // Reset values of held pin controls
   localparam logic HOLD_OUT_RST = 1'b0;
   localparam logic HOLD_OE_RST = 1'b0;

   // Standby pin-level selection values
   localparam logic SPL_KEEP = 1'b0;
   localparam logic SPL_RELEASE = 1'b1;

endpackage

// [hw/pin_cell.sv]
`timescale 1ns/10ps
// One pin: decides drive and internal input from state and function group
module pin_cell
   import pin_state_pkg::*;
(
   input wire logic core_clk_i, // Core clock
   input wire logic resetn_i, // Async reset, active low
   input wire op_state_t state_i, // Current operating state
   input wire logic standby_pin_level_sel_i, // Standby pin level select
   input wire logic [FG_W-1:0] fgroup_i, // Function group of this pin
   input wire logic osc_stopped_i, // Oscillator stopped
   input wire logic port_out_i, // Port output value
   input wire logic port_oe_i, // Port output enable
   input wire logic periph_out_i, // Peripheral output value
   input wire logic periph_oe_i, // Peripheral output enable
   input wire logic pin_i, // Sampled pin level
   output logic pin_o, // Pin drive value
   output logic pin_oe_o, // Pin drive enable
   output logic in_o, // Internal digital input
   output logic analog_en_o // Analog path enable
);
   import pin_state_pkg::*;

   typedef struct packed {
      logic out;
      logic oe;
      logic in_en;
      logic held_out;
      logic held_oe;
      logic analog;
   } cell_state_t;

   cell_state_t s_q, s_d;
   logic in_reset;
   logic released;
   logic holding;

   // Reset-type states ignore port and peripheral pin settings
   assign in_reset = (state_i == ST_POR) || (state_i == ST_EXT_RST)
                     || (state_i == ST_INT_RST);
   assign released = (state_i == ST_STANDBY) && (standby_pin_level_sel_i == SPL_RELEASE);
   assign holding = (state_i == ST_STANDBY) && !released;

   // Next pin control; recomputed whenever state or group changes
   always_comb
   begin
      s_d = s_q;
      s_d.analog = 1'b0;
      s_d.in_en = 1'b1;
      s_d.out = 1'b0;
      s_d.oe = 1'b0;
      case (fgroup_i)
         FG_GPIO, FG_CLK_IN:
         begin
            if (in_reset)
            begin
               s_d.in_en = 1'b0;
            end
            else if (released)
            begin
               s_d.in_en = 1'b0;
            end
            else if (holding)
            begin
               s_d.out = s_q.held_out;
               s_d.oe = s_q.held_oe;
            end
            else
            begin
               // Run keeps tracking live port settings, latched for standby
               s_d.out = (fgroup_i == FG_GPIO) ? port_out_i : 1'b0;
               s_d.oe = (fgroup_i == FG_GPIO) ? port_oe_i : 1'b0;
               s_d.held_out = s_d.out;
               s_d.held_oe = s_d.oe;
            end
         end
         FG_PERIPH, FG_EXT_INT:
         begin
            if (in_reset)
            begin
               s_d.in_en = 1'b0;
            end
            else
            begin
               // Running peripheral keeps driving through hold
               s_d.out = periph_out_i;
               s_d.oe = periph_oe_i;
            end
         end
         FG_OSC_OUT:
         begin
            // Oscillator output never drives; its input is gated off in reset or once it stops
            s_d.in_en = !(in_reset || osc_stopped_i);
         end
         FG_ANALOG:
         begin
            s_d.in_en = 1'b0;
            s_d.analog = !in_reset;
         end
         FG_OSC_IN, FG_ALWAYS_IN:
         begin
            s_d.in_en = 1'b1;
         end
         default:
         begin
            s_d.in_en = 1'b0;
         end
      endcase
   end

   // Register pin control
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_q <= '{out: 1'b0, oe: 1'b0, in_en: 1'b0, held_out: HOLD_OUT_RST,
                  held_oe: HOLD_OE_RST, analog: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign pin_o = s_q.out;
   assign pin_oe_o = s_q.oe;
   assign in_o = s_q.in_en & pin_i;
   assign analog_en_o = s_q.analog;
endmodule

// [hw/pin_state_by_power_mode.sv]
`timescale 1ns/10ps
// Contract
// - External reset input low means external-reset state for pin selection.
// - External reset high: apply internal-reset, run or standby pin states.
// - Standby pin-level select: 0 keeps pins, 1 releases general-purpose pins.
// - Input-enabled pins pass sampled level to internal logic.
// - Gated-off internal input reads constant low.
// - High-impedance disables the output driver fully.
// - All reset states ignore general-purpose pin settings.
// - Run and standby with select 0 keep prior configuration.
// - Held pin with active peripheral follows peripheral output.
// - Held port pin keeps driving last port output.
// - Standby with select 1: general-purpose pin Hi-Z, input forced low.
// - External main clock pin: reset disabled, held, released when select 1.
// - Analog-enabled pins connect to the analog path.
module pin_state_by_power_mode
   import pin_state_pkg::*;
#(
   parameter int PINS = PIN_COUNT
)
(
   input wire logic CORE_CLK_I, // Core clock, 125 MHz
   input wire logic RESETN_I, // Async reset, active low
   input wire logic POR_ACTIVE_I, // Power-on or low-voltage reset
   input wire logic EXTERNAL_RESET_INPUT_N_I, // External reset pin level
   input wire logic INT_RESET_I, // Internal reset active
   input wire logic STANDBY_I, // Standby mode active
   input wire logic STANDBY_PIN_LEVEL_SEL_I, // Standby pin level select
   input wire logic OSC_STOPPED_I, // Oscillator stopped
   input wire logic [PINS*FG_W-1:0] FGROUP_I, // Function group per pin
   input wire logic [PINS-1:0] PORT_OUT_I, // Port output values
   input wire logic [PINS-1:0] PORT_OE_I, // Port output enables
   input wire logic [PINS-1:0] PERIPH_OUT_I, // Peripheral outputs
   input wire logic [PINS-1:0] PERIPH_OE_I, // Peripheral output enables
   input wire logic [PINS-1:0] PIN_I, // Pin levels
   output logic [PINS-1:0] PIN_O, // Pin drive values
   output logic [PINS-1:0] PIN_OE_O, // Pin drive enables, high drives
   output logic [PINS-1:0] IN_O, // Internal inputs
   output logic [PINS-1:0] ANALOG_EN_O, // Analog path enables
   output logic [5:0] STATE_O // Current operating state, one-hot
);
   import pin_state_pkg::*;

   typedef struct packed {
      op_state_t st;
      logic standby_pin_level_sel;
   } top_state_t;

   top_state_t s_q, s_d;

   // Decode operating state, reset sources by priority
   always_comb
   begin
      s_d = s_q;
      s_d.standby_pin_level_sel = STANDBY_PIN_LEVEL_SEL_I;
      if (POR_ACTIVE_I)
      begin
         s_d.st = ST_POR;
      end
      else if (!EXTERNAL_RESET_INPUT_N_I)
      begin
         s_d.st = ST_EXT_RST;
      end
      else if (INT_RESET_I)
      begin
         s_d.st = ST_INT_RST;
      end
      else if (STANDBY_I)
      begin
         s_d.st = ST_STANDBY;
      end
      else
      begin
         s_d.st = ST_RUN;
      end
   end

   // State register; comes out of reset in power-on state
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         s_q <= '{st: ST_POR, standby_pin_level_sel: SPL_KEEP};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign STATE_O = s_q.st;

   // One cell per pin
   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : g_pin
         pin_cell i_pin_cell (
            .core_clk_i(CORE_CLK_I),
            .resetn_i(RESETN_I),
            .state_i(s_q.st),
            .standby_pin_level_sel_i(s_q.standby_pin_level_sel),
            .fgroup_i(FGROUP_I[g*FG_W +: FG_W]),
            .osc_stopped_i(OSC_STOPPED_I),
            .port_out_i(PORT_OUT_I[g]),
            .port_oe_i(PORT_OE_I[g]),
            .periph_out_i(PERIPH_OUT_I[g]),
            .periph_oe_i(PERIPH_OE_I[g]),
            .pin_i(PIN_I[g]),
            .pin_o(PIN_O[g]),
            .pin_oe_o(PIN_OE_O[g]),
            .in_o(IN_O[g]),
            .analog_en_o(ANALOG_EN_O[g])
         );
      end
   endgenerate
endmodule

// [tb/pin_state_by_power_mode_properties.sv]
`timescale 1ns/10ps
// Port-level checks of state decode and pin control
module pin_state_props
   import pin_state_pkg::*;
#(
   parameter int PINS = PIN_COUNT
)
(
   input logic CORE_CLK_I, // Clock
   input logic RESETN_I, // Reset, active low
   input logic POR_ACTIVE_I, // Power-on reset
   input logic EXTERNAL_RESET_INPUT_N_I, // External reset level
   input logic INT_RESET_I, // Internal reset
   input logic STANDBY_I, // Standby
   input logic STANDBY_PIN_LEVEL_SEL_I, // Standby level select
   input logic [PINS*FG_W-1:0] FGROUP_I, // Groups
   input logic [PINS-1:0] PORT_OUT_I, // Port data
   input logic [PINS-1:0] PERIPH_OUT_I, // Peripheral data
   input logic [PINS-1:0] PIN_O, // Drive value
   input logic [PINS-1:0] PIN_OE_O, // Drive enable
   input logic [PINS-1:0] IN_O, // Internal input
   input logic [PINS-1:0] ANALOG_EN_O, // Analog enable
   input logic [5:0] STATE_O // State
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);
   // Pin 0 general purpose while in standby with the given level select
   sequence s_gp_sb(logic sel);
      STATE_O == 6'h10 && STANDBY_PIN_LEVEL_SEL_I == sel && FGROUP_I[2:0] == FG_GPIO;
   endsequence
   a_ext_reset_state: assert property (!POR_ACTIVE_I && !EXTERNAL_RESET_INPUT_N_I |=>
      STATE_O == 6'h02) else $error("ext reset state");
   a_run_state: assert property (!POR_ACTIVE_I && EXTERNAL_RESET_INPUT_N_I && !INT_RESET_I
      && !STANDBY_I |=> STATE_O == 6'h08) else $error("run state");
   a_reset_no_drive: assert property (STATE_O inside {6'h01, 6'h02, 6'h04} |=>
      PIN_OE_O == '0) else $error("drive in reset");
   a_release_hiz: assert property (s_gp_sb(1'b1) ##1 s_gp_sb(1'b1) |=>
      !PIN_OE_O[0] && !IN_O[0]) else $error("release not hi-z");
   a_hold_standby: assert property (s_gp_sb(1'b0) ##1 s_gp_sb(1'b0) ##1 s_gp_sb(1'b0) |=>
      $stable(PIN_O[0]) && $stable(PIN_OE_O[0])) else $error("hold lost");
   a_run_follow: assert property (STATE_O == 6'h08 && FGROUP_I[2:0] == FG_GPIO |=>
      PIN_O[0] == $past(PORT_OUT_I[0])) else $error("port not followed");
   a_periph_follow: assert property (STATE_O == 6'h08 && FGROUP_I[5:3] == FG_PERIPH |=>
      PIN_O[1] == $past(PERIPH_OUT_I[1])) else $error("periph not followed");
   a_analog_on: assert property (STATE_O == 6'h08 && FGROUP_I[17:15] == FG_ANALOG |=>
      ANALOG_EN_O[5]) else $error("analog off");
endmodule

// [tb/board_model.sv]
`timescale 1ns/10ps
// Board side: device drive wins, else the board level
module board_model
(
   input wire logic [7:0] drv_i, // Device drive value
   input wire logic [7:0] oe_i, // Device drive enable
   input wire logic [7:0] lvl_i, // Board level
   output logic [7:0] pin_o // Pin level seen
);
   // A released pin shows the board level, not the last drive
   assign pin_o = (drv_i & oe_i) | (lvl_i & ~oe_i);
endmodule

// [tb/pin_state_by_power_mode_tb.sv]
`timescale 1ns/10ps
module pin_state_by_power_mode_tb;
   import pin_state_pkg::*;
   logic clk = 0, rn = 0, por = 0, xrn = 1, irst = 0, sb = 0, standby_pin_level_sel = 0, osc = 0;
   logic [23:0] fg = '0;
   logic [7:0] po = '0, poe = '0, qo = '0, qoe = '0, pin, lvl = 8'hFF, d, oe, in, an;
   logic [5:0] st;
   int failures = 0, checks = 0, cyc = 0;
   // Clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) if (++cyc == 2000) begin failures++; wrap_up(); end
   pin_state_by_power_mode i_pin_state_by_power_mode (.CORE_CLK_I(clk), .RESETN_I(rn),
      .POR_ACTIVE_I(por), .EXTERNAL_RESET_INPUT_N_I(xrn), .INT_RESET_I(irst), .STANDBY_I(sb),
      .STANDBY_PIN_LEVEL_SEL_I(standby_pin_level_sel), .OSC_STOPPED_I(osc), .FGROUP_I(fg), .PORT_OUT_I(po),
      .PORT_OE_I(poe), .PERIPH_OUT_I(qo), .PERIPH_OE_I(qoe), .PIN_I(pin), .PIN_O(d),
      .PIN_OE_O(oe), .IN_O(in), .ANALOG_EN_O(an), .STATE_O(st));
   board_model i_board_model (.drv_i(d), .oe_i(oe), .lvl_i(lvl), .pin_o(pin));
   task chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin failures++; $display("Error %s exp %h seen %h", n, e, s); end
   endtask
   // Wait for state and pin outputs to settle
   task settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task t_reset();
      @(posedge clk); xrn <= 0; fg <= '0; poe <= 8'hFF; po <= 8'hA5;
      settle();
      chk("state", {2'h0, st}, 8'h02);
      chk("oe", oe, 8'h00);
      chk("in", in, 8'h00);
      @(posedge clk); xrn <= 1; irst <= 1;
      settle();
      chk("state", {2'h0, st}, 8'h04);
   endtask
   task t_run_standby();
      @(posedge clk); irst <= 0;
      settle();
      chk("drive", d, 8'hA5);
      @(posedge clk); sb <= 1;
      settle();
      // Port changes once standby is reached must not reach the pins
      @(posedge clk); po <= 8'h5A; poe <= 8'h00;
      settle();
      chk("held", d, 8'hA5);
      chk("held oe", oe, 8'hFF);
      @(posedge clk); standby_pin_level_sel <= 1;
      settle();
      chk("rel oe", oe, 8'h00);
      chk("rel in", in, 8'h00);
   endtask
   // Pin g takes function group g
   task t_groups();
      @(posedge clk); sb <= 0; standby_pin_level_sel <= 0; fg <= 24'hFAC688; qo <= 8'h02; qoe <= 8'hFF;
      settle();
      chk("analog", an, 8'h20);
      chk("periph", {oe[1], d[1]}, 8'h03);
      chk("always in", {7'h0, in[7]}, 8'h01);
   endtask
   // Clock-type pins: gated by standby release and by a stopped oscillator
   task t_clock_pins();
      chk("clk in run", {7'h0, in[2]}, 8'h01);
      @(posedge clk); sb <= 1; standby_pin_level_sel <= 1; osc <= 1;
      settle();
      chk("clk in rel", {7'h0, in[2]}, 8'h00);
      chk("clk oe rel", {7'h0, oe[2]}, 8'h00);
      chk("osc stop", {7'h0, in[4]}, 8'h00);
      chk("periph sb", {oe[1], d[1]}, 8'h03);
      @(posedge clk); sb <= 0; standby_pin_level_sel <= 0; osc <= 0;
      settle();
      chk("osc run", {7'h0, in[4]}, 8'h01);
   endtask
   task wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rn <= 1;
      t_reset();
      t_run_standby();
      t_groups();
      t_clock_pins();
      wrap_up();
   end
endmodule
bind pin_state_by_power_mode pin_state_props #(.PINS(PINS)) i_pin_state_props (.CORE_CLK_I,
   .RESETN_I, .POR_ACTIVE_I, .EXTERNAL_RESET_INPUT_N_I, .INT_RESET_I, .STANDBY_I,
   .STANDBY_PIN_LEVEL_SEL_I, .FGROUP_I, .PORT_OUT_I, .PERIPH_OUT_I, .PIN_O, .PIN_OE_O, .IN_O,
   .ANALOG_EN_O, .STATE_O);
